// ==== verilog/spc_pkg.sv ====
package spc_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWRUP_NS      = 500;
  localparam int PWRUP_CYC     = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_DLY_CYC  = 1;
  localparam int TRIG_CNT_W    = 8;

  // ---------------------------------------------------------------
  // Serial port frame
  // ---------------------------------------------------------------
  localparam int       SPI_ADDR_W    = 15;
  localparam int       SPI_DATA_W    = 8;
  localparam int       SPI_RD_BIT    = 15;
  localparam int       SPI_CNT_W     = 5;
  localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h10;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [14:0] OFF_EQ_BIAS   = 15'h0268;
  localparam logic [14:0] OFF_SYNTH_EN  = 15'h0280;
  localparam logic [14:0] OFF_SYNTH_STS = 15'h0281;
  localparam logic [14:0] OFF_REF_DIV   = 15'h0289;
  localparam logic [14:0] OFF_TERM1     = 15'h02a7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EQ_PWR_MSB    = 7;
  localparam int EQ_PWR_LSB    = 6;
  localparam int EQ_RSV_MSB    = 5;
  localparam int EN_RECAL_BIT  = 2;
  localparam int EN_RSV_BIT    = 1;
  localparam int EN_POWER_BIT  = 0;
  localparam int STS_CP_HI_BIT = 5;
  localparam int STS_CP_LO_BIT = 4;
  localparam int STS_CP_OK_BIT = 3;
  localparam int STS_LOCK_BIT  = 0;
  localparam int DIV_MSB       = 1;
  localparam int TERM_CAL_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [1:0] EQ_PWR_NORMAL = 2'h0;
  localparam logic [1:0] EQ_PWR_LOW    = 2'h1;
  localparam logic [1:0] EQ_PWR_RST    = EQ_PWR_LOW;
  localparam logic [5:0] EQ_RSV_RST    = 6'h04;
  localparam logic [1:0] DIV_RST       = 2'h0;
  localparam logic [1:0] DIV_CODE_BY1  = 2'h2;

  typedef enum logic [1:0] {
    SPC_PH_INSTR,
    SPC_PH_DATA,
    SPC_PH_DONE
  } spc_phase_e;

endpackage

// ==== verilog/spc_trig.sv ====
module spc_trig #(
  parameter int DELAY = 1
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic level,
  output logic      start
);
  import spc_pkg::*;

  // ---------------------------------------------------------------
  // Rising-edge launch with delay
  // ---------------------------------------------------------------
  logic                  level_d_r;
  logic [TRIG_CNT_W-1:0] count_r;
  logic [TRIG_CNT_W-1:0] count_nxt;
  logic                  start_r;
  logic                  rise;
  logic                  fire;

  // A held level never relaunches; only a fresh low-to-high does
  assign rise      = level & ~level_d_r;
  assign fire      = level & ~rise & (count_r == TRIG_CNT_W'(1));
  // Dropping the level cancels a pending launch
  assign count_nxt = !level ? '0 :
                     rise ? TRIG_CNT_W'(DELAY) :
                     (count_r != '0) ? TRIG_CNT_W'(count_r - TRIG_CNT_W'(1)) : count_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level_d_r <= 1'b0;
      count_r   <= '0;
      start_r   <= 1'b0;
    end else begin
      level_d_r <= level;
      count_r   <= count_nxt;
      start_r   <= fire;
    end
  end

  assign start = start_r;

endmodule

// ==== verilog/spc_regs.sv ====
// What this block does
// RQ1: Equalizer power field bits 7:6, resets 01
// RQ2: Recal bit rising edge reruns synth calibration
// RQ3: Held recal bit never retriggers; clear first
// RQ4: Enable bit powers synth, then calibrates
// RQ5: Software sets reference and divider before enable
// RQ6: Status bit 5 shows charge pump too high
// RQ7: Status bit 4 shows charge pump too low
// RQ8: Status bit 3 shows charge pump cal valid
// RQ9: Status bit 0 shows synthesizer locked
// RQ10: Two-bit reference divide factor at bits 1:0
// RQ11: Software picks divider code from lane rate
// RQ12: Termination bank1 bit0 rising starts calibration
// RQ13: Read-only, reserved bits ignore writes; the code stores reserved EN bit 1 and EQ bits 5:0
module spc_regs (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_b,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  input  wire logic       cp_above_range_in,
  input  wire logic       cp_below_range_in,
  input  wire logic       cp_cal_done_in,
  input  wire logic       synth_locked_in,
  output logic [1:0]      equalizer_power_select,
  output logic            synth_power_on,
  output logic            synth_cal_start,
  output logic            synth_recal_start,
  output logic [1:0]      reference_divide_factor,
  output logic            termination_cal_start_bank1
);
  import spc_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic       sclk_s1_r;
  logic       sclk_s2_r;
  logic       sclk_d_r;
  logic       cs_s1_r;
  logic       cs_s2_r;
  logic       sdi_s1_r;
  logic       sdi_s2_r;
  logic [3:0] sts_s1_r;
  logic [3:0] sts_s2_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r  <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      sdi_s1_r  <= 1'b0;
      sdi_s2_r  <= 1'b0;
      sts_s1_r  <= 4'h0;
      sts_s2_r  <= 4'h0;
    end else begin
      sclk_s1_r <= spi_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r  <= sclk_s2_r;
      cs_s1_r   <= spi_cs_b;
      cs_s2_r   <= cs_s1_r;
      sdi_s1_r  <= spi_sdi;
      sdi_s2_r  <= sdi_s1_r;
      sts_s1_r  <= {cp_above_range_in, cp_below_range_in, cp_cal_done_in, synth_locked_in};
      sts_s2_r  <= sts_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Serial frame decode
  // ---------------------------------------------------------------
  // Oversampled port: serial clock must stay well below ref_clk / 8
  logic                  frame_act;
  logic                  sclk_rise;
  logic                  sclk_fall;
  spc_phase_e            phase_r;
  spc_phase_e            phase_nxt;
  logic [SPI_CNT_W-1:0]  bit_cnt_r;
  logic [22:0]           shift_r;
  logic                  rd_r;
  logic [14:0]           addr_r;
  logic [7:0]            tx_r;
  logic                  sdo_r;
  logic                  sdo_oe_r;
  logic                  take_bit;
  logic                  instr_done;
  logic [15:0]           instr_word;
  logic                  commit;
  logic [7:0]            wdata;
  logic                  data_out;

  assign frame_act  = ~cs_s2_r;
  assign sclk_rise  = sclk_s2_r & ~sclk_d_r;
  assign sclk_fall  = ~sclk_s2_r & sclk_d_r;
  assign take_bit   = frame_act & sclk_rise & (phase_r != SPC_PH_DONE);
  assign instr_word = {shift_r[14:0], sdi_s2_r};
  assign instr_done = take_bit & (phase_r == SPC_PH_INSTR) & (bit_cnt_r == SPI_INSTR_LAST);
  assign wdata      = {shift_r[6:0], sdi_s2_r};
  assign commit     = take_bit & (phase_r == SPC_PH_DATA) & (bit_cnt_r == SPI_FRAME_LAST) &
                      ~rd_r;
  assign data_out   = frame_act & sclk_fall & rd_r & (phase_r != SPC_PH_INSTR);

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      SPC_PH_INSTR: begin
        if (instr_done) begin
          phase_nxt = SPC_PH_DATA;
        end
      end
      SPC_PH_DATA: begin
        if (take_bit && bit_cnt_r == SPI_FRAME_LAST) begin
          phase_nxt = SPC_PH_DONE;
        end
      end
      SPC_PH_DONE: begin
        phase_nxt = SPC_PH_DONE;
      end
      default: begin
        phase_nxt = SPC_PH_INSTR;
      end
    endcase
    if (!frame_act) begin
      phase_nxt = SPC_PH_INSTR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_r   <= SPC_PH_INSTR;
      bit_cnt_r <= '0;
      shift_r   <= '0;
    end else begin
      phase_r <= phase_nxt;
      if (!frame_act) begin
        bit_cnt_r <= '0;
      end else if (take_bit) begin
        bit_cnt_r <= SPI_CNT_W'(bit_cnt_r + SPI_CNT_W'(1));
        shift_r   <= {shift_r[21:0], sdi_s2_r};
      end
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [1:0] eq_pwr_r;
  logic [5:0] eq_rsv_r;
  logic       recal_r;
  logic       en_rsv_r;
  logic       en_r;
  logic [1:0] div_r;
  logic       term_r;
  logic [3:0] sts_r;
  logic       wr_eq;
  logic       wr_en;
  logic       wr_div;
  logic       wr_term;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] off);
    hit = (a == off);
  endfunction

  assign wr_eq   = commit & hit(addr_r, OFF_EQ_BIAS);
  assign wr_en   = commit & hit(addr_r, OFF_SYNTH_EN);
  assign wr_div  = commit & hit(addr_r, OFF_REF_DIV);
  assign wr_term = commit & hit(addr_r, OFF_TERM1);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      eq_pwr_r <= EQ_PWR_RST;
      eq_rsv_r <= EQ_RSV_RST;
      recal_r  <= 1'b0;
      en_rsv_r <= 1'b0;
      en_r     <= 1'b0;
      div_r    <= DIV_RST;
      term_r   <= 1'b0;
      sts_r    <= 4'h0;
    end else begin
      if (wr_eq) begin
        eq_pwr_r <= wdata[EQ_PWR_MSB:EQ_PWR_LSB]; // RQ1
        eq_rsv_r <= wdata[EQ_RSV_MSB:0];
      end
      if (wr_en) begin
        recal_r  <= wdata[EN_RECAL_BIT]; // RQ3
        en_rsv_r <= wdata[EN_RSV_BIT];
        en_r     <= wdata[EN_POWER_BIT];
      end
      if (wr_div) begin
        div_r <= wdata[DIV_MSB:0]; // RQ10
      end
      if (wr_term) begin
        term_r <= wdata[TERM_CAL_BIT];
      end
      sts_r <= sts_s2_r; // RQ6 RQ7 RQ8 RQ9
    end
  end

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------
  // Status and constant-zero reserved bits have no write path at all; reserved EN bit 1 and EQ bits 5:0 are stored
  logic [7:0] rd_val;
  logic [7:0] rd_sts;

  assign rd_sts = {2'h0, sts_r[3], sts_r[2], sts_r[1], 2'h0, sts_r[0]}; // RQ13
  assign rd_val = hit(instr_word[14:0], OFF_EQ_BIAS)   ? {eq_pwr_r, eq_rsv_r} :
                  hit(instr_word[14:0], OFF_SYNTH_EN)  ? {5'h00, recal_r, en_rsv_r, en_r} :
                  hit(instr_word[14:0], OFF_SYNTH_STS) ? rd_sts :
                  hit(instr_word[14:0], OFF_REF_DIV)   ? {6'h00, div_r} :
                  hit(instr_word[14:0], OFF_TERM1)     ? {7'h00, term_r} : 8'h00; // RQ13

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_r     <= 1'b0;
      addr_r   <= '0;
      tx_r     <= 8'h00;
      sdo_r    <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      if (!frame_act) begin
        rd_r     <= 1'b0;
        sdo_oe_r <= 1'b0;
      end else if (instr_done) begin
        rd_r   <= instr_word[SPI_RD_BIT];
        addr_r <= instr_word[14:0];
        tx_r   <= rd_val;
      end else if (data_out) begin
        sdo_r    <= tx_r[7];
        sdo_oe_r <= 1'b1;
        tx_r     <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Calibration launchers
  // ---------------------------------------------------------------
  spc_trig #(.DELAY(TRIG_DLY_CYC)) u_recal (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (recal_r),
    .start   (synth_recal_start)
  ); // RQ2 RQ3

  // Currents settle for the power-up time before calibration begins
  spc_trig #(.DELAY(PWRUP_CYC)) u_pwrcal (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (en_r),
    .start   (synth_cal_start)
  ); // RQ4 RQ5

  spc_trig #(.DELAY(TRIG_DLY_CYC)) u_term (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (term_r),
    .start   (termination_cal_start_bank1)
  ); // RQ12

  assign equalizer_power_select  = eq_pwr_r;
  assign synth_power_on          = en_r;
  assign reference_divide_factor = div_r;
  assign spi_sdo                 = sdo_r;
  assign spi_sdo_oe              = sdo_oe_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int A_TRIG = TRIG_DLY_CYC + 1;
  localparam int A_CAL  = PWRUP_CYC + 1;

  property p_eq_reset;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(rst_b) |-> (equalizer_power_select == EQ_PWR_LOW);
  endproperty
  a_eq_reset: assert property (p_eq_reset) else $error("eq power reset wrong"); // RQ1
  property p_eq_write;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_eq |=> (equalizer_power_select == $past(wdata[7:6]));
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("eq power write lost"); // RQ1
  property p_recal_rise;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(recal_r) |-> ##A_TRIG synth_recal_start;
  endproperty
  a_recal_rise: assert property (p_recal_rise) else $error("recal not launched"); // RQ2
  property p_recal_held;
    @(posedge ref_clk) disable iff (!rst_b)
      recal_r [*4] |-> !synth_recal_start;
  endproperty
  a_recal_held: assert property (p_recal_held) else $error("held recal retriggered"); // RQ3
  property p_pwr_cal;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(synth_power_on) ##1 synth_power_on [*2] |-> ##(A_CAL - A_TRIG)
        (synth_cal_start || !$past(synth_power_on));
  endproperty
  a_pwr_cal: assert property (p_pwr_cal) else $error("power-up calibration missing"); // RQ4
  property p_cp_high;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b, 3) |-> (rd_sts[STS_CP_HI_BIT] == $past(cp_above_range_in, 3));
  endproperty
  a_cp_high: assert property (p_cp_high) else $error("cp high flag wrong"); // RQ6
  property p_cp_low;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b, 3) |-> (rd_sts[STS_CP_LO_BIT] == $past(cp_below_range_in, 3));
  endproperty
  a_cp_low: assert property (p_cp_low) else $error("cp low flag wrong"); // RQ7
  property p_cp_ok;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b, 3) |-> (rd_sts[STS_CP_OK_BIT] == $past(cp_cal_done_in, 3));
  endproperty
  a_cp_ok: assert property (p_cp_ok) else $error("cp valid flag wrong"); // RQ8
  property p_lock;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b, 3) |-> (rd_sts[STS_LOCK_BIT] == $past(synth_locked_in, 3));
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag wrong"); // RQ9
  property p_div_write;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_div |=> (reference_divide_factor == $past(wdata[1:0]));
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost"); // RQ10
  property p_term_rise;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(term_r) |-> ##A_TRIG termination_cal_start_bank1;
  endproperty
  a_term_rise: assert property (p_term_rise) else $error("term cal not launched"); // RQ12
  property p_rsv_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      instr_done |-> (rd_sts[7:6] == 2'h0 && rd_sts[2:1] == 2'h0 &&
                      (!hit(instr_word[14:0], OFF_SYNTH_EN) || rd_val[7:3] == 5'h00));
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero"); // RQ13
endmodule

// ==== test/serdes_pll_calib_control_test.sv ====
module serdes_pll_calib_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       spi_sclk = 1'b0;
  logic       spi_cs_b = 1'b1;
  logic       spi_sdi = 1'b0;
  logic       spi_sdo;
  logic       spi_sdo_oe;
  logic [3:0] sts_in = 4'h0;
  logic [1:0] equalizer_power_select;
  logic       synth_power_on;
  logic       synth_cal_start;
  logic       synth_recal_start;
  logic [1:0] reference_divide_factor;
  logic       termination_cal_start_bank1;
  int         fails = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         pwr_cyc = 0;
  int         cal_cyc = 0;
  int         n_cal = 0;
  int         n_recal = 0;
  int         n_term = 0;
  logic       pwr_q = 1'b0;

  spc_regs u_dut (
    .ref_clk                     (ref_clk),
    .rst_b                       (rst_b),
    .spi_sclk                    (spi_sclk),
    .spi_cs_b                    (spi_cs_b),
    .spi_sdi                     (spi_sdi),
    .spi_sdo                     (spi_sdo),
    .spi_sdo_oe                  (spi_sdo_oe),
    .cp_above_range_in           (sts_in[0]),
    .cp_below_range_in           (sts_in[1]),
    .cp_cal_done_in              (sts_in[2]),
    .synth_locked_in             (sts_in[3]),
    .equalizer_power_select      (equalizer_power_select),
    .synth_power_on              (synth_power_on),
    .synth_cal_start             (synth_cal_start),
    .synth_recal_start           (synth_recal_start),
    .reference_divide_factor     (reference_divide_factor),
    .termination_cal_start_bank1 (termination_cal_start_bank1)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Pulse monitor
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pwr_q <= synth_power_on;
    if (synth_power_on === 1'b1 && pwr_q !== 1'b1) pwr_cyc <= cyc;
    if (synth_cal_start === 1'b1) begin
      n_cal <= n_cal + 1;
      cal_cyc <= cyc;
    end
    if (synth_recal_start === 1'b1) n_recal <= n_recal + 1;
    if (termination_cal_start_bank1 === 1'b1) n_term <= n_term + 1;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // Half periods of 8 clocks keep well above the 4-clock sync limit
  task automatic spi_xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                          output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, a, wd};
    rdat = 8'h00;
    spi_cs_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi <= frame[i];
      repeat (8) @(posedge ref_clk);
      if (i < 8) rdat[i] = spi_sdo;
      spi_sclk <= 1'b1;
      repeat (8) @(posedge ref_clk);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    spi_cs_b <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi_xfer(1'b0, a, d, x);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] x;
    spi_xfer(1'b1, a, 8'h00, x);
    chk(x, e);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({6'h00, equalizer_power_select}, 8'h01);
    chk({7'h00, synth_power_on}, 8'h00);
    rd_chk(OFF_EQ_BIAS, 8'h44);
    rd_chk(OFF_SYNTH_EN, 8'h00);
    rd_chk(OFF_SYNTH_STS, 8'h00);
    rd_chk(OFF_REF_DIV, 8'h00);
    rd_chk(OFF_TERM1, 8'h00);
  endtask

  task automatic t_eq_mode();
    wr(OFF_EQ_BIAS, 8'h00);
    chk({6'h00, equalizer_power_select}, {6'h00, EQ_PWR_NORMAL});
    rd_chk(OFF_EQ_BIAS, 8'h00);
    wr(OFF_EQ_BIAS, 8'h7a);
    chk({6'h00, equalizer_power_select}, {6'h00, EQ_PWR_LOW});
    rd_chk(OFF_EQ_BIAS, 8'h7a);
  endtask

  task automatic t_divider();
    for (int c = 0; c < 4; c++) begin
      wr(OFF_REF_DIV, {6'h3f, c[1:0]});
      chk({6'h00, reference_divide_factor}, {6'h00, c[1:0]});
      rd_chk(OFF_REF_DIV, {6'h00, c[1:0]});
    end
    // Leave the lane setting at the low-rate code before enabling
    wr(OFF_REF_DIV, {6'h00, DIV_CODE_BY1});
    chk({6'h00, reference_divide_factor}, 8'h02);
  endtask

  task automatic t_enable();
    wr(OFF_SYNTH_EN, 8'h01);
    chk({7'h00, synth_power_on}, 8'h01);
    repeat (PWRUP_CYC + 20) @(posedge ref_clk);
    chk(8'(n_cal), 8'h01);
    chk(8'(cal_cyc - pwr_cyc), 8'(PWRUP_CYC + 1));
  endtask

  task automatic t_recal();
    wr(OFF_SYNTH_EN, 8'h05);
    chk(8'(n_recal), 8'h01);
    wr(OFF_SYNTH_EN, 8'h05);
    chk(8'(n_recal), 8'h01);
    wr(OFF_SYNTH_EN, 8'h01);
    wr(OFF_SYNTH_EN, 8'h05);
    chk(8'(n_recal), 8'h02);
    rd_chk(OFF_SYNTH_EN, 8'h05);
    wr(OFF_SYNTH_EN, 8'hfb);
    rd_chk(OFF_SYNTH_EN, 8'h03);
    chk(8'(n_cal), 8'h01);
    chk(8'(n_recal), 8'h02);
  endtask

  task automatic t_status();
    logic [3:0] pat [5];
    logic [7:0] exp [5];
    pat = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    exp = '{8'h20, 8'h10, 8'h08, 8'h01, 8'h39};
    for (int k = 0; k < 5; k++) begin
      sts_in <= pat[k];
      repeat (6) @(posedge ref_clk);
      rd_chk(OFF_SYNTH_STS, exp[k]);
    end
    wr(OFF_SYNTH_STS, 8'h00);
    rd_chk(OFF_SYNTH_STS, 8'h39);
    sts_in <= 4'h0;
    repeat (6) @(posedge ref_clk);
    rd_chk(OFF_SYNTH_STS, 8'h00);
  endtask

  task automatic t_term();
    wr(OFF_TERM1, 8'h01);
    chk(8'(n_term), 8'h01);
    wr(OFF_TERM1, 8'hff);
    rd_chk(OFF_TERM1, 8'h01);
    chk(8'(n_term), 8'h01);
    wr(OFF_TERM1, 8'h00);
    wr(OFF_TERM1, 8'h01);
    chk(8'(n_term), 8'h02);
  endtask

  task automatic t_unmapped();
    wr(15'h0269, 8'hff);
    rd_chk(15'h0300, 8'h00);
    rd_chk(OFF_EQ_BIAS, 8'h7a);
    chk({7'h00, spi_sdo_oe}, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_eq_mode();
    t_divider();
    t_enable();
    t_recal();
    t_status();
    t_term();
    t_unmapped();
    complete_run();
  end

  // Roughly 42 frames of about 420 clocks each, with margin
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
endmodule
